// *** bit_sync.sv ***
// Two-flop synchroniser for a level or toggle
module bit_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);
	logic meta_r;
	logic q_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			q_r    <= 1'b0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end
	assign q = q_r;
endmodule : bit_sync

// *** framer_cfg.svh ***
// Register offsets, reset values and word-format constants of the framer
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH

`define A_TRAIN    8'h82
`define A_MARKER   8'h83
`define A_DARK     8'h84
`define A_IMG      8'h85
`define A_CRC      8'h86
`define A_TRCLS    8'h87
`define A_MODE     8'h88
`define A_NBLACK   8'h89
`define A_W0F      8'h8a
`define A_W0L      8'h8b
`define A_W1F      8'h8c
`define A_W1L      8'h8d
`define A_STATUS   8'h8e

`define RST_TRAIN  10'h3a6
`define RST_MARKER 7'h2a
`define RST_DARK   10'h015
`define RST_IMG    10'h035
`define RST_CRC    10'h059
`define RST_TRCLS  10'h3a6
`define MIN_NBLACK 12'h001
`define RST_W0F    12'h000
`define RST_W0L    12'h9c3
`define RST_W1F    12'hfff
`define RST_W1L    12'h000

`define FB         3'h5
`define FF         3'h6
`define RB         3'h1
`define RF         3'h2

`define LANE_W     10
`define WIDE_TOP   4'h9
`define NARROW_TOP 4'h7

`endif

// *** framer_pkg.sv ***
// Types shared by the framer modules
package framer_pkg;
	typedef logic [9:0] word_t;
	typedef struct packed {
		word_t       sync;
		word_t [3:0] lane;
	} slot_t;
	typedef enum {ST_IDLE, ST_NEXT, ST_HDR_CODE, ST_HDR_ID, ST_BODY,
		ST_TAIL_CODE, ST_TAIL_ID} frame_state_t;
endpackage : framer_pkg

// *** link_receiver.sv ***
// Receiver model: deserializes the five link lanes into word slots
module link_receiver (
	input  wire logic       link_clk,
	input  wire logic       rst,
	input  wire logic [3:0] lane_bit,
	input  wire logic       sync_bit,
	input  wire logic       clk_out,
	input  wire logic       narrow,
	output framer_pkg::slot_t word,
	output logic            word_stb,
	output logic            clk_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	import framer_pkg::*;
	localparam word_t TRAIN_W = 10'h3a6;
	logic [9:0]      sh_s;
	logic [3:0][9:0] sh_l;
	logic            lock;
	logic            nar_q;
	logic            ck_q;
	int              cnt;
	initial clk_bad = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Sample mid-bit, away from the edge where the lanes change
	always @(negedge link_clk) begin
		word_stb = 1'b0;
		sh_s = {sh_s[8:0], sync_bit};
		for (int g = 0; g < 4; g++)
			sh_l[g] = {sh_l[g][8:0], lane_bit[g]};
		if (lock && clk_out === ck_q)
			clk_bad = 1'b1;
		ck_q = clk_out;
		if (rst) begin
			lock = 1'b0;
			nar_q = narrow;
		end else if (!lock) begin
			if (nar_q ? sh_s[7:0] == TRAIN_W[9:2] : sh_s == TRAIN_W) begin
				lock = 1'b1;
				cnt = 0;
			end
		end else begin
			cnt++;
			// Wide training runs on until the first narrow slot, a delimiter,
			// which never starts with the training prefix
			if (narrow && !nar_q && cnt == 8 && sh_s[7:0] != TRAIN_W[9:2])
				nar_q = 1'b1;
			if (cnt == (nar_q ? 8 : 10)) begin
				cnt = 0;
				word.sync = nar_q ? {2'b00, sh_s[7:0]} : sh_s;
				for (int g = 0; g < 4; g++)
					word.lane[g] = nar_q ? {2'b00, sh_l[g][7:0]} : sh_l[g];
				word_stb = 1'b1;
			end
		end
	end
endmodule : link_receiver

// *** link_serializer.sv ***
// Link-clock serializer: four data lanes, sync lane, forwarded clock
`include "framer_cfg.svh"
module link_serializer (
	input  wire logic  link_clk,
	input  wire logic  rst,
	slot_if.link       sl,
	output logic [3:0] lane_bit,
	output logic       sync_bit,
	output logic       clk_out
);
	import framer_pkg::*;

	logic        req_s;
	logic        ack_r;
	slot_t       cur_r;
	slot_t       idle_r;
	logic        nar_r;
	logic        idle_nar_r;
	logic [3:0]  cnt_r;
	logic [3:0]  lane_r;
	logic        sync_r;
	logic        clk_out_r;
	logic [3:0]  nxt_lane;

	bit_sync u_req (
		.clk (link_clk),
		.rst (rst),
		.d   (sl.req_tgl),
		.q   (req_s)
	);

	wire       boundary = cnt_r == 4'h0;
	wire       pending  = req_s != ack_r;
	wire       load_nar = pending ? sl.narrow : idle_nar_r;
	wire [3:0] top      = load_nar ? `NARROW_TOP : `WIDE_TOP;

	// Slot data is stable until acknowledged, so it is read directly
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ack_r      <= 1'b0;
			cur_r      <= {`RST_TRCLS, {4{`RST_TRAIN}}};
			idle_r     <= {`RST_TRCLS, {4{`RST_TRAIN}}};
			nar_r      <= 1'b0;
			idle_nar_r <= 1'b0;
			cnt_r      <= 4'h0;
		end else if (boundary) begin
			cnt_r <= top;
			nar_r <= load_nar;
			if (pending) begin
				cur_r      <= sl.slot;
				idle_r     <= sl.idle;
				idle_nar_r <= sl.narrow;
				ack_r      <= req_s;
			end else begin
				cur_r <= idle_r;
			end
		end else begin
			cnt_r <= cnt_r - 4'h1;
		end
	end

	// One bit counter for all five lanes keeps word edges aligned
	for (genvar g = 0; g < 4; g++) begin : g_bit
		assign nxt_lane[g] = cur_r.lane[g][cnt_r];
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lane_r    <= 4'h0;
			sync_r    <= 1'b0;
			clk_out_r <= 1'b0;
		end else begin
			lane_r    <= nxt_lane;
			sync_r    <= cur_r.sync[cnt_r];
			clk_out_r <= ~clk_out_r;
		end
	end

	assign sl.ack_tgl = ack_r;
	assign lane_bit   = lane_r;
	assign sync_bit   = sync_r;
	assign clk_out    = clk_out_r;

	property p_word_len;
		@(posedge link_clk) disable iff (rst)
		boundary |=> cnt_r == (nar_r ? `NARROW_TOP : `WIDE_TOP);
	endproperty
	a_word_len: assert property (p_word_len)
		else $error("word length does not match mode");

	property p_fwd_clk;
		@(posedge link_clk) disable iff (rst)
		clk_out_r |=> !clk_out_r ##1 clk_out_r;
	endproperty
	a_fwd_clk: assert property (p_fwd_clk)
		else $error("forwarded clock stopped toggling");
endmodule : link_serializer

// *** serial_pixel_output_framer.sv ***
// Serial pixel output framer: registers, line sequencing, sync words
`include "framer_cfg.svh"
module serial_pixel_output_framer (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        link_clk,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [11:0] reg_wdata,
	output logic      [11:0] reg_rdata,
	input  wire logic        frame_go,
	input  wire logic        seq_valid,
	output logic             seq_ready,
	input  wire logic [39:0] seq_data,
	input  wire logic        seq_crc,
	input  wire logic        seq_line_end,
	output logic      [3:0]  lane_bit,
	output logic             sync_bit,
	output logic             link_clk_out
);
	import framer_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [9:0]   train_r;
	logic [6:0]   marker_r;
	logic [9:0]   dark_r;
	logic [9:0]   img_r;
	logic [9:0]   crc_r;
	logic [9:0]   trcls_r;
	logic         narrow_r;
	logic [11:0]  nblack_r;
	logic [11:0]  w0f_r;
	logic [11:0]  w0l_r;
	logic [11:0]  w1f_r;
	logic [11:0]  w1l_r;
	logic [11:0]  rdata_r;
	frame_state_t st_r;
	frame_state_t st_nxt;
	logic [11:0]  row_r;
	logic [11:0]  row_nxt;
	logic [11:0]  black_cnt_r;
	logic [11:0]  black_cnt_nxt;
	logic         line_black_r;
	logic         line_black_nxt;
	logic [39:0]  pix_r;
	logic         pix_full_r;
	logic         pix_crc_r;
	logic         pix_end_r;
	logic         seq_ready_r;
	logic         req_tgl_r;
	slot_t        slot_r;
	slot_t        idle_r;
	logic         slot_nar_r;
	logic         ack_s;
	logic         busy;
	word_t        emit_sync;
	word_t [3:0]  emit_lanes;
	word_t [3:0]  idle_lanes;
	logic [11:0]  rd_mux;

	function automatic logic in_win(input logic [11:0] row,
		input logic [11:0] first, input logic [11:0] last);
		in_win = row >= first && row <= last;
	endfunction : in_win

	function automatic word_t fmt_word(input logic [9:0] w,
		input logic nar);
		fmt_word = nar ? {2'h0, w[9:2]} : w;
	endfunction : fmt_word

	function automatic word_t fmt_code(input logic [2:0] kind,
		input logic [6:0] mark, input logic nar);
		fmt_code = nar ? {2'h0, kind, mark[6:2]} : {kind, mark};
	endfunction : fmt_code

	function automatic word_t fmt_id(input logic [2:0] id,
		input logic nar);
		fmt_id = nar ? {5'h0, id, 2'h0} : {7'h0, id};
	endfunction : fmt_id

	////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			train_r  <= `RST_TRAIN;
			marker_r <= `RST_MARKER;
			dark_r   <= `RST_DARK;
			img_r    <= `RST_IMG;
			crc_r    <= `RST_CRC;
			trcls_r  <= `RST_TRCLS;
			narrow_r <= 1'b0;
			nblack_r <= `MIN_NBLACK;
			w0f_r    <= `RST_W0F;
			w0l_r    <= `RST_W0L;
			w1f_r    <= `RST_W1F;
			w1l_r    <= `RST_W1L;
		end else if (reg_wr) begin
			case (reg_addr)
				`A_TRAIN:  train_r  <= reg_wdata[9:0];
				`A_MARKER: marker_r <= reg_wdata[6:0];
				`A_DARK:   dark_r   <= reg_wdata[9:0];
				`A_IMG:    img_r    <= reg_wdata[9:0];
				`A_CRC:    crc_r    <= reg_wdata[9:0];
				`A_TRCLS:  trcls_r  <= reg_wdata[9:0];
				`A_MODE:   narrow_r <= reg_wdata[0];
				// At least one black line is always read out
				`A_NBLACK: nblack_r <= (reg_wdata == 12'h000) ?
					`MIN_NBLACK : reg_wdata;
				`A_W0F:    w0f_r    <= reg_wdata;
				`A_W0L:    w0l_r    <= reg_wdata;
				`A_W1F:    w1f_r    <= reg_wdata;
				`A_W1L:    w1l_r    <= reg_wdata;
				default: ;
			endcase
		end
	end

	assign rd_mux =
		(reg_addr == `A_TRAIN)  ? {2'h0, train_r} :
		(reg_addr == `A_MARKER) ? {5'h0, marker_r} :
		(reg_addr == `A_DARK)   ? {2'h0, dark_r} :
		(reg_addr == `A_IMG)    ? {2'h0, img_r} :
		(reg_addr == `A_CRC)    ? {2'h0, crc_r} :
		(reg_addr == `A_TRCLS)  ? {2'h0, trcls_r} :
		(reg_addr == `A_MODE)   ? {11'h0, narrow_r} :
		(reg_addr == `A_NBLACK) ? nblack_r :
		(reg_addr == `A_W0F)    ? w0f_r :
		(reg_addr == `A_W0L)    ? w0l_r :
		(reg_addr == `A_W1F)    ? w1f_r :
		(reg_addr == `A_W1L)    ? w1l_r :
		(reg_addr == `A_STATUS) ?
			{9'h0, busy, st_r != ST_IDLE, line_black_r} : 12'h000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 12'h000;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Line and window decoding
	wire        in0        = in_win(row_r, w0f_r, w0l_r);
	wire        in1        = in_win(row_r, w1f_r, w1l_r);
	wire [2:0]  hi_win     = in1 ? 3'h1 : 3'h0;
	wire [11:0] hi_first   = in1 ? w1f_r : w0f_r;
	wire [11:0] hi_last    = in1 ? w1l_r : w0l_r;
	wire [11:0] max_last   = (w1l_r > w0l_r) ? w1l_r : w0l_r;
	wire [2:0]  first_win  = (w1f_r < w0f_r) ? 3'h1 : 3'h0;
	wire        more_black = black_cnt_r < nblack_r;
	wire        hdr_first  = !line_black_r && row_r == hi_first;
	wire        tail_last  = !line_black_r && row_r == hi_last;
	wire [2:0]  hdr_kind   = hdr_first ? `FB : `RB;
	wire [2:0]  tail_kind  = tail_last ? `FF : `RF;
	wire [2:0]  win_id     = line_black_r ? first_win : hi_win;
	wire        code_slot  = st_r == ST_HDR_CODE || st_r == ST_TAIL_CODE;
	wire        id_slot    = st_r == ST_HDR_ID || st_r == ST_TAIL_ID;
	wire        body_slot  = st_r == ST_BODY;
	assign busy = req_tgl_r != ack_s;
	wire        emit       = code_slot || id_slot || (body_slot && pix_full_r);
	wire        send       = emit && !busy;
	wire        consume    = send && body_slot;
	wire        take       = seq_valid && seq_ready_r;
	wire        pix_full_nxt = take || (pix_full_r && !consume);
	wire [9:0]  cls = pix_crc_r ? crc_r : (line_black_r ? dark_r : img_r);

	assign emit_sync = code_slot ?
		fmt_code(st_r == ST_HDR_CODE ? hdr_kind : tail_kind,
			marker_r, narrow_r) :
		id_slot ? fmt_id(win_id, narrow_r) :
		fmt_word(cls, narrow_r);

	// Delimiter and identifier slots keep image words off the lanes
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign emit_lanes[g] = fmt_word(body_slot ?
			pix_r[g*`LANE_W +: `LANE_W] : train_r, narrow_r);
		assign idle_lanes[g] = fmt_word(train_r, narrow_r);
	end

	////////////////////////////////////////////////////////////////////
	// Pixel holding word from the readout sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pix_r       <= 40'h0;
			pix_crc_r   <= 1'b0;
			pix_end_r   <= 1'b0;
			pix_full_r  <= 1'b0;
			seq_ready_r <= 1'b0;
		end else begin
			if (take) begin
				pix_r     <= seq_data;
				pix_crc_r <= seq_crc;
				pix_end_r <= seq_line_end;
			end
			pix_full_r  <= pix_full_nxt;
			seq_ready_r <= !pix_full_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frame sequencing; rows ascend, black lines first
	always_comb begin
		st_nxt         = st_r;
		row_nxt        = row_r;
		black_cnt_nxt  = black_cnt_r;
		line_black_nxt = line_black_r;
		case (st_r)
			ST_IDLE: if (frame_go) begin
				st_nxt        = ST_NEXT;
				row_nxt       = 12'h000;
				black_cnt_nxt = 12'h000;
			end
			ST_NEXT: if (more_black) begin
				line_black_nxt = 1'b1;
				st_nxt         = ST_HDR_CODE;
			end else if (in0 || in1) begin
				line_black_nxt = 1'b0;
				st_nxt         = ST_HDR_CODE;
			end else if (row_r >= max_last) begin
				st_nxt = ST_IDLE;
			end else begin
				row_nxt = row_r + 12'h001;
			end
			ST_HDR_CODE: if (send) begin
				st_nxt = ST_HDR_ID;
			end
			ST_HDR_ID: if (send) begin
				st_nxt = ST_BODY;
			end
			ST_BODY: if (consume && pix_end_r) begin
				st_nxt = ST_TAIL_CODE;
			end
			ST_TAIL_CODE: if (send) begin
				st_nxt = ST_TAIL_ID;
			end
			ST_TAIL_ID: if (send) begin
				st_nxt = ST_NEXT;
				if (line_black_r) begin
					black_cnt_nxt = black_cnt_r + 12'h001;
				end else if (row_r >= max_last) begin
					st_nxt = ST_IDLE;
				end else begin
					row_nxt = row_r + 12'h001;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r         <= ST_IDLE;
			row_r        <= 12'h000;
			black_cnt_r  <= 12'h000;
			line_black_r <= 1'b0;
		end else begin
			st_r         <= st_nxt;
			row_r        <= row_nxt;
			black_cnt_r  <= black_cnt_nxt;
			line_black_r <= line_black_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slot handshake to the link clock; one slot in flight at a time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_r     <= {`RST_TRCLS, {4{`RST_TRAIN}}};
			idle_r     <= {`RST_TRCLS, {4{`RST_TRAIN}}};
			slot_nar_r <= 1'b0;
			req_tgl_r  <= 1'b0;
		end else if (send) begin
			slot_r     <= {emit_sync, emit_lanes};
			idle_r     <= {fmt_word(trcls_r, narrow_r), idle_lanes};
			slot_nar_r <= narrow_r;
			req_tgl_r  <= ~req_tgl_r;
		end
	end

	slot_if sl ();
	assign sl.slot    = slot_r;
	assign sl.idle    = idle_r;
	assign sl.narrow  = slot_nar_r;
	assign sl.req_tgl = req_tgl_r;

	bit_sync u_ack (
		.clk (clk),
		.rst (rst),
		.d   (sl.ack_tgl),
		.q   (ack_s)
	);

	link_serializer u_link (
		.link_clk (link_clk),
		.rst      (rst),
		.sl       (sl),
		.lane_bit (lane_bit),
		.sync_bit (sync_bit),
		.clk_out  (link_clk_out)
	);

	assign reg_rdata = rdata_r;
	assign seq_ready = seq_ready_r;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_id_after_code;
		send && code_slot |=> id_slot;
	endproperty
	a_id_after_code: assert property (p_id_after_code)
		else $error("delimiter not followed by identifier");

	property p_id_bits;
		send && id_slot && !narrow_r |=> slot_r.sync[9:3] == 7'h0;
	endproperty
	a_id_bits: assert property (p_id_bits)
		else $error("identifier word has high bits set");

	property p_marker;
		send && code_slot && !narrow_r |=>
			slot_r.sync[6:0] == $past(marker_r);
	endproperty
	a_marker: assert property (p_marker)
		else $error("delimiter marker bits wrong");

	property p_black_rows;
		send && code_slot && line_black_r && !narrow_r |->
			emit_sync[9:7] inside {`RB, `RF};
	endproperty
	a_black_rows: assert property (p_black_rows)
		else $error("black line carries a frame code");

	property p_overlap_hi;
		send && id_slot && in1 && !line_black_r && !narrow_r |=>
			slot_r.sync[2:0] == 3'h1;
	endproperty
	a_overlap_hi: assert property (p_overlap_hi)
		else $error("overlap line not tagged with highest window");

	property p_dark_class;
		send && body_slot && line_black_r && !pix_crc_r && !narrow_r |=>
			slot_r.sync == $past(dark_r);
	endproperty
	a_dark_class: assert property (p_dark_class)
		else $error("black pixel word has wrong class");

	property p_narrow;
		send && narrow_r |=>
			slot_r.sync[9:8] == 2'h0 && slot_r.lane[0][9:8] == 2'h0;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("narrow word uses upper bits");

	property p_inflight;
		send |=> busy [*2];
	endproperty
	a_inflight: assert property (p_inflight)
		else $error("slot sent before acknowledge");

	property p_black_first;
		st_r == ST_HDR_CODE && !line_black_r |-> black_cnt_r >= nblack_r;
	endproperty
	a_black_first: assert property (p_black_first)
		else $error("window line before black lines done");

	property p_line_close;
		consume && pix_end_r |=> st_r == ST_TAIL_CODE;
	endproperty
	a_line_close: assert property (p_line_close)
		else $error("line end not followed by closing code");

	c_frame_begin: cover property (send && st_r == ST_HDR_CODE && hdr_first);
	c_overlap: cover property (send && id_slot && in0 && in1);
	c_narrow_body: cover property (send && narrow_r && body_slot);
endmodule : serial_pixel_output_framer

// *** slot_if.sv ***
// Word-slot handshake between the framer core and the link serializer
interface slot_if;
	import framer_pkg::*;
	slot_t slot;
	slot_t idle;
	logic  narrow;
	logic  req_tgl;
	logic  ack_tgl;
	modport core (output slot, idle, narrow, req_tgl, input ack_tgl);
	modport link (input slot, idle, narrow, req_tgl, output ack_tgl);
endinterface : slot_if

// *** test_serial_pixel_output_framer.sv ***
// Testbench: registers, framed lines over the link, narrow mode
`include "framer_cfg.svh"
`define CHK(g, e, m) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); \
	end \
end
module test_serial_pixel_output_framer;
	timeunit 1ns;
	timeprecision 1ps;
	import framer_pkg::*;
	localparam logic [39:0] TR4 = {4{10'h3a6}};
	logic        clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [11:0] reg_wdata = 12'h000;
	logic [11:0] reg_rdata;
	logic        frame_go = 1'b0;
	logic        seq_valid = 1'b0;
	logic        seq_ready;
	logic [39:0] seq_data = 40'h0;
	logic        seq_crc = 1'b0;
	logic        seq_line_end = 1'b0;
	logic [3:0]  lane_bit;
	logic        sync_bit;
	logic        link_clk_out;
	slot_t       rx_word;
	logic        rx_stb;
	logic        clk_bad;
	logic        nar_mode = 1'b0;
	logic [6:0]  mark = 7'h2a;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          seed = 25341;
	slot_t       exp_q [$];
	logic [7:0]  ra [13] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
		8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e};
	logic [11:0] rv [13] = '{12'h3a6, 12'h02a, 12'h015, 12'h035, 12'h059,
		12'h3a6, 12'h000, 12'h001, 12'h000, 12'h9c3, 12'hfff, 12'h000, 12'h000};
	// Sensor clock stays at its normal rate in both word modes
	always #12.5 clk = ~clk;
	always #15 link_clk = ~link_clk;
	serial_pixel_output_framer dut_u (.clk(clk), .rst(rst), .link_clk(link_clk),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_go(frame_go),
		.seq_valid(seq_valid), .seq_ready(seq_ready), .seq_data(seq_data),
		.seq_crc(seq_crc), .seq_line_end(seq_line_end), .lane_bit(lane_bit),
		.sync_bit(sync_bit), .link_clk_out(link_clk_out));
	link_receiver rx_u (.link_clk(link_clk), .rst(rst), .lane_bit(lane_bit),
		.sync_bit(sync_bit), .clk_out(link_clk_out), .narrow(nar_mode),
		.word(rx_word), .word_stb(rx_stb), .clk_bad(clk_bad));
	////////////////////////////////////////////////////////////////////////
	function automatic word_t dlm(logic [2:0] t);
		return nar_mode ? {2'b00, t, mark[6:2]} : {t, mark};
	endfunction : dlm
	function automatic word_t wid(logic [2:0] i);
		return nar_mode ? {5'b0, i, 2'b0} : {7'b0, i};
	endfunction : wid
	function automatic word_t cls(word_t r);
		return nar_mode ? {2'b00, r[9:2]} : r;
	endfunction : cls
	function automatic logic [39:0] nl(logic [39:0] v);
		for (int g = 0; g < 4; g++)
			nl[g*10 +: 10] = nar_mode ? {2'b00, v[g*10+2 +: 8]} : v[g*10 +: 10];
	endfunction : nl
	task automatic reg_acc(logic w, logic [7:0] a, logic [11:0] d);
		@(negedge clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		@(negedge clk);
	endtask : reg_acc
	task automatic rd_chk(logic [7:0] a, logic [11:0] e);
		reg_acc(1'b0, a, 12'h000);
		`CHK(reg_rdata, e, "register")
	endtask : rd_chk
	task automatic put_word(logic [39:0] d, logic c, logic e);
		int n;
		n = 0;
		@(negedge clk);
		seq_valid = 1'b1;
		seq_data = d;
		seq_crc = c;
		seq_line_end = e;
		while (seq_ready !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		seq_valid = 1'b0;
	endtask : put_word
	// Notes a whole line before its words go out, then sends them
	task automatic line(logic [2:0] h, logic [2:0] t, logic [2:0] i,
		word_t c, logic go);
		logic [39:0] d;
		logic [39:0] k;
		d = 40'({$random(seed), $random(seed)});
		k = 40'({$random(seed), $random(seed)});
		exp_q.push_back({dlm(h), nl(TR4)});
		exp_q.push_back({wid(i), nl(TR4)});
		exp_q.push_back({cls(c), nl(d)});
		exp_q.push_back({cls(10'h059), nl(k)});
		exp_q.push_back({dlm(t), nl(TR4)});
		exp_q.push_back({wid(i), nl(TR4)});
		if (go) begin
			@(negedge clk);
			frame_go = 1'b1;
			@(negedge clk);
			frame_go = 1'b0;
			// Header and identifier leave; the block then waits for pixels
			repeat (80) @(negedge clk);
			rd_chk(`A_STATUS, 12'h003);
		end
		put_word(d, 1'b0, 1'b0);
		put_word(k, 1'b1, 1'b1);
	endtask : line
	task automatic frame(int nb, int f0, int l0, int f1, int l1);
		logic in0;
		logic in1;
		for (int b = 0; b < nb; b++) begin
			line(`RB, `RF, 3'h0, 10'h015, b == 0);
			if (b == 0) begin
				// A second start while busy must change nothing
				reg_acc(1'b0, `A_STATUS, 12'h000);
				frame_go = 1'b1;
				@(negedge clk);
				frame_go = 1'b0;
			end
		end
		for (int r = 0; r < 8; r++) begin
			in0 = r >= f0 && r <= l0;
			in1 = r >= f1 && r <= l1;
			if (in0 || in1)
				line(r == (in1 ? f1 : f0) ? `FB : `RB,
					r == (in1 ? l1 : l0) ? `FF : `RF,
					{2'b00, in1}, 10'h035, 1'b0);
		end
	endtask : frame
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		`CHK(exp_q.size(), 0, "words left")
	endtask : drain
	task end_of_test;
		$display("mismatches %0d, comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////
	always @(posedge link_clk) begin
		if (rx_stb === 1'b1) begin
			// Wide training goes on after a mode change until a slot is sent
			if (rx_word.sync === 10'h3a6) begin
				`CHK(rx_word.lane, TR4, "training lanes")
			end else if (rx_word.sync === cls(10'h3a6)) begin
				`CHK(rx_word.lane, nl(TR4), "training lanes")
			end else if (exp_q.size() == 0) begin
				`CHK(rx_word.sync, 10'h3a6, "unexpected")
			end else begin
				`CHK(rx_word.sync, exp_q[0].sync, "sync")
				`CHK(rx_word.lane, exp_q[0].lane, "lanes")
				void'(exp_q.pop_front());
			end
		end
	end
	initial begin
		#1500000;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int j = 0; j < 13; j++)
			rd_chk(ra[j], rv[j]);
		reg_acc(1'b1, 8'h7f, 12'h123);
		rd_chk(8'h7f, 12'h000);
		reg_acc(1'b1, `A_NBLACK, 12'h000);
		rd_chk(`A_NBLACK, 12'h001);
		reg_acc(1'b1, `A_STATUS, 12'h007);
		rd_chk(`A_STATUS, 12'h000);
		mark = 7'($random(seed));
		reg_acc(1'b1, `A_MARKER, {5'b0, mark});
		rd_chk(`A_MARKER, {5'b0, mark});
		reg_acc(1'b1, `A_NBLACK, 12'h002);
		reg_acc(1'b1, `A_W0F, 12'h002);
		reg_acc(1'b1, `A_W0L, 12'h004);
		reg_acc(1'b1, `A_W1F, 12'h003);
		reg_acc(1'b1, `A_W1L, 12'h006);
		frame(2, 2, 4, 3, 6);
		drain;
		reg_acc(1'b1, `A_MODE, 12'h001);
		nar_mode = 1'b1;
		reg_acc(1'b1, `A_NBLACK, 12'h001);
		reg_acc(1'b1, `A_W0F, 12'h001);
		reg_acc(1'b1, `A_W0L, 12'h002);
		reg_acc(1'b1, `A_W1F, 12'hfff);
		reg_acc(1'b1, `A_W1L, 12'h000);
		repeat (200) @(negedge clk);
		frame(1, 1, 2, 4095, 0);
		drain;
		`CHK(clk_bad, 1'b0, "forwarded clock")
		end_of_test;
	end
endmodule : test_serial_pixel_output_framer
